// *** hw/trmsc_consts.svh ***
// offsets, field positions, codes and timing counts of the tape command interpreter
`ifndef TRMSC_CONSTS_SVH
`define TRMSC_CONSTS_SVH
// register byte offsets
`define TRMSC_OFF_CMD    5'h00
`define TRMSC_OFF_CTRL   5'h04
`define TRMSC_OFF_RESULT 5'h08
`define TRMSC_OFF_XSTAT  5'h0C
`define TRMSC_OFF_ERRCNT 5'h10
// command codes
`define TRMSC_CMD_RD     8'h80
`define TRMSC_CMD_WFM    8'h60
`define TRMSC_CMD_RFM    8'hA0
`define TRMSC_CMD_WRITE_NO_UNDERRUN_CMD   8'h41
`define TRMSC_CMD_READ_EXTENDED_STATUS_CMD   8'hC0
// control fields
`define TRMSC_CTRL_RESET 0
`define TRMSC_CTRL_CONT  1
`define TRMSC_CTRL_SEL0  2
// result flag positions
`define TRMSC_RES_DONE   0
`define TRMSC_RES_REJ    1
`define TRMSC_RES_FM     2
`define TRMSC_RES_NODATA 3
`define TRMSC_RES_EOM    4
`define TRMSC_RES_UNREC  5
`define TRMSC_RES_MARG   6
`define TRMSC_RES_FAULT  7
`define TRMSC_RES_CASS   8
`define TRMSC_RES_ERRS   9'h1FA
// retry limits and byte counts
`define TRMSC_TRY_UNREC  5'h10
`define TRMSC_TRY_MARG   5'h08
`define TRMSC_XS_BYTES   6
// reset values and timing
`define TRMSC_SEL_RST    2'h0
`define TRMSC_CLK_MHZ    200
`define TRMSC_START_MS   1000
`endif

// *** hw/trmsc_pkg.sv ***
// types shared by the tape command interpreter
package trmsc_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_RD,
        S_RFM,
        S_ERASE,
        S_WFM,
        S_WRITE_NO_UNDERRUN_CMD
    } trmsc_state_e;

    // drive-side status pins
    typedef struct packed {
        logic cass_ok;
        logic wprot;
        logic moving;
        logic blk_done;
        logic blk_bad;
        logic fmark;
        logic gap;
        logic leader;
        logic last_track;
        logic last_block;
        logic tape_end;
        logic erase_ok;
        logic next_ready;
        logic rom_err;
        logic sysmem_err;
        logic bufmem_err;
        logic pos_lost;
    } trmsc_tape_in_s;

    typedef logic [7:0] trmsc_byte_t;
endpackage : trmsc_pkg

// *** hw/trmsc_top.sv ***
// tape command interpreter: read, file mark, no-underrun and extended status commands
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`include "trmsc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module trmsc_top
    import trmsc_pkg::*;
#(
    parameter int unsigned START_TMO_CYC = `TRMSC_START_MS * `TRMSC_CLK_MHZ * 1000,
    parameter trmsc_byte_t IDENT         = 8'hA5 // arbitrary value
) (
    // clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    // avalon-mm slave
    input  wire logic [4:0]     i_avs_address,
    input  wire logic           i_avs_read,
    input  wire logic           i_avs_write,
    input  wire logic [31:0]    i_avs_writedata,
    output logic      [31:0]    o_avs_readdata,
    output logic                o_avs_waitrequest,
    // drive pins
    input  wire trmsc_tape_in_s i_tape,
    input  wire logic [7:0]     i_track,
    input  wire logic [15:0]    i_blk_addr,
    output logic                o_motor_run,
    output logic                o_read_en,
    output logic                o_write_en,
    output logic                o_erase_en,
    output logic                o_rewrite_prev,
    output logic                o_rewind,
    output logic                o_exception_n
);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    trmsc_tape_in_s s1_r, tin, prv_r;
    logic [23:0]    p1_r, pos_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r  <= '0;
            tin   <= '0;
            prv_r <= '0;
            p1_r  <= '0;
            pos_r <= '0;
        end else begin
            s1_r  <= i_tape;
            tin   <= s1_r;
            prv_r <= tin;
            p1_r  <= {i_track, i_blk_addr};
            pos_r <= p1_r;
        end
    end

    // a pulse is seen once it is sampled high at one rising clock edge
    logic blk_p, bad_p, fm_p, gap_p, lead_p;
    assign blk_p  = tin.blk_done & ~prv_r.blk_done;
    assign bad_p  = blk_p & tin.blk_bad;
    assign fm_p   = tin.fmark & ~prv_r.fmark;
    assign gap_p  = tin.gap & ~prv_r.gap;
    assign lead_p = tin.leader & ~prv_r.leader;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic ack_r, rd_fire, wr_fire;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign rd_fire = i_avs_read & ack_r;
    assign wr_fire = i_avs_write & ack_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
        end
    end

    logic       cmd_wr, ctl_wr, res_wr, xs_rd;
    logic [7:0] code;
    assign code   = i_avs_writedata[7:0];
    assign cmd_wr = wr_fire && (i_avs_address == `TRMSC_OFF_CMD);
    assign ctl_wr = wr_fire && (i_avs_address == `TRMSC_OFF_CTRL);
    assign res_wr = wr_fire && (i_avs_address == `TRMSC_OFF_RESULT);
    assign xs_rd  = rd_fire && (i_avs_address == `TRMSC_OFF_XSTAT);

    // ------------------------------------------------------------
    // control and selection
    // ------------------------------------------------------------
    logic [1:0] sel_r;
    logic       cont_r, sel_ok, flt_clr;
    assign sel_ok  = (sel_r == 2'h1) || (sel_r == 2'h2);
    assign flt_clr = ctl_wr && i_avs_writedata[`TRMSC_CTRL_RESET];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sel_r  <= `TRMSC_SEL_RST;
            cont_r <= 1'b0;
        end else if (ctl_wr) begin
            sel_r  <= i_avs_writedata[`TRMSC_CTRL_SEL0+:2];
            cont_r <= i_avs_writedata[`TRMSC_CTRL_CONT];
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    trmsc_state_e state_r, state_nxt;
    logic [4:0]   att_r, att_nxt;
    logic [31:0]  tmo_r;
    logic [8:0]   res_set;
    logic [6:1]   flt_set;
    logic         reading, writing, tmo_hit, rewind_nxt, run_ok;

    assign reading = (state_r == S_RD) || (state_r == S_RFM);
    assign writing = (state_r == S_ERASE) || (state_r == S_WFM) || (state_r == S_WRITE_NO_UNDERRUN_CMD);
    assign tmo_hit = (state_r != S_IDLE) && !tin.moving && (tmo_r == START_TMO_CYC - 1);
    assign run_ok  = !cmd_wr && tin.cass_ok && !tmo_hit;
    assign att_nxt = att_r + 5'h01;

    always_comb begin
        state_nxt  = state_r;
        res_set    = '0;
        flt_set    = '0;
        rewind_nxt = 1'b0;
        flt_set[6] = tin.rom_err;
        flt_set[5] = tin.sysmem_err;
        flt_set[4] = tin.bufmem_err;
        flt_set[2] = tin.pos_lost;
        if (cmd_wr) begin
            case (code)
                `TRMSC_CMD_RD, `TRMSC_CMD_RFM: begin
                    // a read may not interrupt a write or another read
                    if (!sel_ok || !tin.cass_ok || writing || reading) begin
                        res_set[`TRMSC_RES_REJ] = 1'b1;
                    end else begin
                        state_nxt = (code == `TRMSC_CMD_RD) ? S_RD : S_RFM;
                    end
                end
                `TRMSC_CMD_WFM, `TRMSC_CMD_WRITE_NO_UNDERRUN_CMD: begin
                    if (!sel_ok || !tin.cass_ok || tin.wprot || reading) begin
                        res_set[`TRMSC_RES_REJ] = 1'b1;
                    end else if (code == `TRMSC_CMD_WRITE_NO_UNDERRUN_CMD) begin
                        state_nxt = S_WRITE_NO_UNDERRUN_CMD;
                    end else begin
                        state_nxt = (pos_r[23:16] == 8'h00) ? S_ERASE : S_WFM;
                    end
                end
                `TRMSC_CMD_READ_EXTENDED_STATUS_CMD: begin
                    state_nxt = state_r;
                end
                default: begin
                    res_set[`TRMSC_RES_REJ] = 1'b1;
                end
            endcase
        end else if (state_r != S_IDLE && !tin.cass_ok) begin
            state_nxt = S_IDLE;
            res_set[`TRMSC_RES_CASS] = 1'b1;
        end else if (tmo_hit) begin
            state_nxt = S_IDLE;
            res_set[`TRMSC_RES_FAULT] = 1'b1;
            flt_set[3] = 1'b1;
        end else begin
            case (state_r)
                S_RD: begin
                    if (bad_p && att_nxt == `TRMSC_TRY_UNREC) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_UNREC] = 1'b1;
                    end else if (fm_p) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_FM] = 1'b1;
                    end else if (gap_p) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_NODATA] = 1'b1;
                    end else if (lead_p && tin.last_track) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_NODATA] = 1'b1;
                        res_set[`TRMSC_RES_EOM] = 1'b1;
                    end else if (lead_p && !tin.last_block) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_FAULT] = 1'b1;
                        flt_set[2] = 1'b1;
                    end
                end
                S_RFM: begin
                    if (bad_p && att_nxt == `TRMSC_TRY_UNREC) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_UNREC] = 1'b1;
                        rewind_nxt = 1'b1;
                    end else if (fm_p) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_FM] = 1'b1;
                        res_set[`TRMSC_RES_DONE] = 1'b1;
                    end else if (gap_p) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_NODATA] = 1'b1;
                    end
                end
                S_ERASE: begin
                    // erase current is judged at the end of the erased stretch
                    if (blk_p && !tin.erase_ok) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_FAULT] = 1'b1;
                        flt_set[1] = 1'b1;
                    end else if (blk_p) begin
                        state_nxt = S_WFM;
                    end
                end
                S_WFM: begin
                    if (bad_p && att_nxt == `TRMSC_TRY_UNREC) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_UNREC] = 1'b1;
                        rewind_nxt = 1'b1;
                    end else if (bad_p && att_nxt == `TRMSC_TRY_MARG && !cont_r) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_MARG] = 1'b1;
                    end else if (lead_p && tin.last_track) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_EOM] = 1'b1;
                    end else if (blk_p && !tin.blk_bad) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_DONE] = 1'b1;
                    end
                end
                S_WRITE_NO_UNDERRUN_CMD: begin
                    if (tin.tape_end) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_EOM] = 1'b1;
                    end else if (blk_p && pos_r[23:16] == 8'h00 && !tin.erase_ok) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_FAULT] = 1'b1;
                        flt_set[1] = 1'b1;
                    end else if (blk_p && tin.next_ready) begin
                        state_nxt = S_IDLE;
                        res_set[`TRMSC_RES_DONE] = 1'b1;
                    end
                end
                default: begin
                    state_nxt = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // attempts restart on each change of state and after a clean block
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            att_r <= '0;
        end else if (state_nxt != state_r || (blk_p && !tin.blk_bad)) begin
            att_r <= '0;
        end else if (bad_p) begin
            att_r <= att_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tmo_r <= '0;
        end else if (state_r == S_IDLE || tin.moving || tmo_hit) begin
            tmo_r <= '0;
        end else begin
            tmo_r <= tmo_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // drive outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_motor_run    <= 1'b0;
            o_read_en      <= 1'b0;
            o_write_en     <= 1'b0;
            o_erase_en     <= 1'b0;
            o_rewrite_prev <= 1'b0;
            o_rewind       <= 1'b0;
        end else begin
            o_motor_run    <= state_nxt != S_IDLE;
            o_read_en      <= (state_nxt == S_RD) || (state_nxt == S_RFM);
            o_write_en     <= (state_nxt == S_WFM) || (state_nxt == S_WRITE_NO_UNDERRUN_CMD);
            o_erase_en     <= state_nxt == S_ERASE;
            o_rewrite_prev <= (state_nxt == S_WRITE_NO_UNDERRUN_CMD) && !tin.next_ready;
            o_rewind       <= rewind_nxt;
        end
    end

    // ------------------------------------------------------------
    // result flags, fault byte, error count
    // ------------------------------------------------------------
    logic [8:0]  res_r;
    logic [6:1]  flt_r;
    logic [15:0] err_r;
    trmsc_byte_t flt_byte;
    assign flt_byte = {|flt_r, flt_r, 1'b0};

    // write-one-to-clear; a same-cycle event wins
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            res_r <= '0;
        end else if (res_wr) begin
            res_r <= (res_r & ~i_avs_writedata[8:0]) | res_set;
        end else begin
            res_r <= res_r | res_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flt_r <= '0;
        end else if (flt_clr) begin
            flt_r <= flt_set;
        end else begin
            flt_r <= flt_r | flt_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_r <= '0;
        end else if (bad_p && state_r != S_IDLE) begin
            err_r <= err_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_exception_n <= 1'b1;
        end else begin
            o_exception_n <= ~|(res_r & `TRMSC_RES_ERRS);
        end
    end

    // ------------------------------------------------------------
    // extended status snapshot
    // ------------------------------------------------------------
    trmsc_byte_t xs_src [`TRMSC_XS_BYTES];
    trmsc_byte_t xs_mem [`TRMSC_XS_BYTES];
    logic [2:0]  xs_idx_r;
    logic        read_extended_status_cmd_wr;
    assign read_extended_status_cmd_wr   = cmd_wr && (code == `TRMSC_CMD_READ_EXTENDED_STATUS_CMD);
    assign xs_src[0] = IDENT;
    assign xs_src[1] = flt_byte;
    assign xs_src[2] = {6'h00, sel_r};
    assign xs_src[3] = pos_r[23:16];
    assign xs_src[4] = pos_r[15:8];
    assign xs_src[5] = pos_r[7:0];

    // taken as one snapshot so the six bytes agree with each other
    for (genvar g = 0; g < `TRMSC_XS_BYTES; g++) begin : g_xs
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                xs_mem[g] <= '0;
            end else if (read_extended_status_cmd_wr) begin
                xs_mem[g] <= xs_src[g];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            xs_idx_r <= 3'h6;
        end else if (read_extended_status_cmd_wr) begin
            xs_idx_r <= 3'h0;
        end else if (xs_rd && xs_idx_r < 3'h6) begin
            xs_idx_r <= xs_idx_r + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                `TRMSC_OFF_CMD:    o_avs_readdata <= {29'h0, state_r};
                `TRMSC_OFF_CTRL:   o_avs_readdata <= {28'h0, sel_r, cont_r, 1'b0};
                `TRMSC_OFF_RESULT: o_avs_readdata <= {15'h0, flt_byte, res_r};
                `TRMSC_OFF_XSTAT:  o_avs_readdata <= (xs_idx_r < 3'h6) ?
                                       {23'h0, 1'b1, xs_mem[xs_idx_r]} : 32'h0000_0000;
                `TRMSC_OFF_ERRCNT: o_avs_readdata <= {16'h0, err_r};
                default:           o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_read_reject: assert property (
        (cmd_wr && code == `TRMSC_CMD_RD && !sel_ok && state_r == S_IDLE)
        |=> state_r == S_IDLE && res_r[`TRMSC_RES_REJ]) else $error("read accepted while unselected");
    a_eject_abort: assert property (
        (!cmd_wr && state_r != S_IDLE && !tin.cass_ok)
        |=> state_r == S_IDLE && res_r[`TRMSC_RES_CASS]) else $error("ejection did not abort");
    a_read_unrec: assert property (
        (run_ok && state_r == S_RD && bad_p && att_r == 5'h0F)
        |=> res_r[`TRMSC_RES_UNREC] && state_r == S_IDLE) else $error("sixteenth bad read missed");
    a_read_fmark: assert property (
        (run_ok && state_r == S_RD && fm_p && !bad_p)
        |=> res_r[`TRMSC_RES_FM] && !o_read_en) else $error("file mark did not end read");
    a_mark_rewind: assert property (
        (run_ok && state_r == S_WFM && bad_p && att_r == 5'h0F)
        |=> o_rewind ##1 !o_rewind) else $error("no single rewind pulse");
    a_erase_first: assert property (
        (cmd_wr && code == `TRMSC_CMD_WFM && state_nxt == S_ERASE)
        |=> o_erase_en && !o_write_en) else $error("track 0 mark not erased first");
    a_fault_clear: assert property (
        (flt_clr && flt_set == 6'h00) |=> flt_byte == 8'h00) else $error("reset left fault bits");
    a_exc_assert: assert property (
        $rose(res_r[`TRMSC_RES_UNREC]) |=> !o_exception_n) else $error("exception line not asserted");
    a_addr_order: assert property (
        read_extended_status_cmd_wr |=> xs_mem[4] == $past(pos_r[15:8]) && xs_mem[5] == $past(pos_r[7:0]))
        else $error("block address bytes misordered");

endmodule : trmsc_top

`default_nettype wire

// *** test/trmsc_drive_model.sv ***
// drive mechanism pin model for the tape command interpreter bench
`timescale 1ns/100ps
`default_nettype none

module trmsc_drive_model
    import trmsc_pkg::*;
(
    // clock and head control
    input  wire logic           i_clk,
    input  wire logic           i_motor_run,
    // drive status pins
    output var trmsc_tape_in_s  o_tape,
    output logic [7:0]          o_track,
    output logic [15:0]         o_blk_addr
);
    // seated cassette, last block read, erase current present, next block ready
    trmsc_tape_in_s st   = 17'h1_00B0;
    logic [7:0]     trk  = 8'h02;
    logic [15:0]    addr = 16'h5A3C;
    logic           stall = 1'b0;

    // tape moves whenever the motor runs; stall holds it still to provoke a start timeout
    always_comb begin
        o_tape        = st;
        o_tape.moving = i_motor_run & ~stall;
    end
    assign o_track    = trk;
    assign o_blk_addr = addr;

    // one head event, held 4 clocks so the synchroniser sees a clean edge
    task automatic strobe(input int k, input logic b);
        @(posedge i_clk);
        st.blk_bad <= b;
        case (k)
            0: st.blk_done <= 1'b1;
            1: st.fmark <= 1'b1;
            2: st.gap <= 1'b1;
            3: st.leader <= 1'b1;
            default: st.cass_ok <= 1'b0;
        endcase
        repeat (4) @(posedge i_clk);
        {st.blk_done, st.fmark, st.gap, st.leader, st.cass_ok} <= 5'b0_0001;
        repeat (4) @(posedge i_clk);
    endtask : strobe
endmodule : trmsc_drive_model
`default_nettype wire

// *** test/test_trmsc_top.sv ***
// self-checking bench for the tape command interpreter
`timescale 1ns/100ps
`default_nettype none

module test_trmsc_top
    import trmsc_pkg::*;
;
    logic           i_clk;
    logic           i_rstn    = 1'b0;
    logic [4:0]     avs_adr   = 5'h00;
    logic           avs_rd    = 1'b0;
    logic           avs_wr    = 1'b0;
    logic [31:0]    avs_wdata = 32'h0000_0000;
    logic [31:0]    avs_rdata;
    logic           avs_wait;
    trmsc_tape_in_s tape;
    logic [7:0]     track;
    logic [15:0]    blk_addr;
    logic           motor_run;
    logic           erase_en;
    logic           read_en;
    logic           write_en;
    logic           rewind;
    logic [16:0]    rewinds   = 17'h0_0000;
    logic           rewrite_prev;
    logic           exception_n;
    logic [31:0]    q;
    int             bad_count = 0;
    int             compares  = 0;
    logic [7:0]     xs [6]    = '{8'h3B, 8'h84, 8'h01, 8'h02, 8'h5A, 8'h3C};

    // identity value is arbitrary; short start timeout keeps the run brief
    trmsc_top #(.START_TMO_CYC(50), .IDENT(8'h3B)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_avs_address(avs_adr), .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
        .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_tape(tape), .i_track(track),
        .i_blk_addr(blk_addr), .o_motor_run(motor_run), .o_read_en(read_en), .o_write_en(write_en),
        .o_erase_en(erase_en), .o_rewrite_prev(rewrite_prev), .o_rewind(rewind), .o_exception_n(exception_n));
    trmsc_drive_model u_drv (.i_clk(i_clk), .i_motor_run(motor_run), .o_tape(tape), .o_track(track),
        .o_blk_addr(blk_addr));

    // ----------------------------------------
    // bus access and checking
    // ----------------------------------------
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_adr   <= a;
        avs_wdata <= d;
        avs_wr    <= w;
        avs_rd    <= ~w;
        do @(posedge i_clk); while (avs_wait !== 1'b0);
        q = avs_rdata;
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
        @(posedge i_clk);
    endtask : bus

    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // issue a command, play head events, then check result, fault byte and exception line
    task automatic go(input logic [7:0] c, input int k, input int n, input logic b, input logic [16:0] e);
        // pin changes made just before need the synchroniser delay to reach the design
        repeat (4) @(posedge i_clk);
        bus(1'b1, 5'h00, {24'h00_0000, c});
        repeat (n) u_drv.strobe(k, b);
        repeat (6) @(posedge i_clk);
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[16:0], e);
        chk({16'h0000, exception_n}, {16'h0000, ~|(e[8:0] & 9'h1FA)});
        bus(1'b1, 5'h08, 32'h0000_01FF);
    endtask : go

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (rewind === 1'b1) begin
            rewinds <= rewinds + 17'h0_0001;
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[16:0], 17'h0_0000);
        go(8'h80, 0, 0, 1'b0, 17'h0_0002);
        bus(1'b1, 5'h04, 32'h0000_0004);
        u_drv.st.cass_ok <= 1'b0;
        go(8'h80, 0, 0, 1'b0, 17'h0_0002);
        go(8'hA0, 0, 0, 1'b0, 17'h0_0002);
        u_drv.st.cass_ok <= 1'b1;
        u_drv.st.wprot <= 1'b1;
        go(8'h60, 0, 0, 1'b0, 17'h0_0002);
        go(8'h41, 0, 0, 1'b0, 17'h0_0002);
        u_drv.st.wprot <= 1'b0;
        go(8'h80, 1, 1, 1'b0, 17'h0_0004);
        go(8'h80, 2, 1, 1'b0, 17'h0_0008);
        go(8'h80, 0, 16, 1'b1, 17'h0_0020);
        bus(1'b0, 5'h10, 32'h0000_0000);
        chk(q[16:0], 17'h0_0010);
        go(8'h80, 4, 1, 1'b0, 17'h0_0100);
        u_drv.st.last_track <= 1'b1;
        go(8'h80, 3, 1, 1'b0, 17'h0_0018);
        u_drv.st.last_track <= 1'b0;
        u_drv.st.last_block <= 1'b0;
        go(8'h80, 3, 1, 1'b0, 17'h1_0880);
        u_drv.st.last_block <= 1'b1;
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[16:0], 17'h1_0800);
        bus(1'b1, 5'h00, 32'h0000_00C0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'h0C, 32'h0000_0000);
            chk(q[16:0], {8'h00, 1'b1, xs[i]});
        end
        u_drv.stall <= 1'b1;
        go(8'h80, 0, 7, 1'b0, 17'h1_1880);
        u_drv.stall <= 1'b0;
        bus(1'b1, 5'h04, 32'h0000_0005);
        bus(1'b0, 5'h08, 32'h0000_0000);
        chk(q[16:0], 17'h0_0000);
        u_drv.trk <= 8'h00;
        repeat (4) @(posedge i_clk);
        bus(1'b1, 5'h00, 32'h0000_0060);
        repeat (2) @(posedge i_clk);
        bus(1'b0, 5'h00, 32'h0000_0000);
        chk({14'h0000, q[2:0]}, 17'h0_0003);
        chk({15'h0000, write_en, erase_en}, 17'h0_0001);
        go(8'h60, 0, 2, 1'b0, 17'h0_0001);
        u_drv.st.erase_ok <= 1'b0;
        go(8'h60, 0, 1, 1'b0, 17'h1_0480);
        u_drv.st.erase_ok <= 1'b1;
        u_drv.trk <= 8'h02;
        bus(1'b1, 5'h04, 32'h0000_0005);
        go(8'h60, 0, 8, 1'b1, 17'h0_0040);
        bus(1'b1, 5'h04, 32'h0000_0006);
        go(8'h60, 0, 16, 1'b1, 17'h0_0020);
        chk(rewinds, 17'h0_0001);
        go(8'hA0, 0, 16, 1'b1, 17'h0_0020);
        chk(rewinds, 17'h0_0002);
        go(8'hA0, 1, 1, 1'b0, 17'h0_0005);
        u_drv.st.next_ready <= 1'b0;
        bus(1'b1, 5'h00, 32'h0000_0041);
        repeat (6) @(posedge i_clk);
        chk({16'h0000, rewrite_prev}, 17'h0_0001);
        chk({15'h0000, write_en, read_en}, 17'h0_0002);
        u_drv.st.next_ready <= 1'b1;
        go(8'h41, 0, 1, 1'b0, 17'h0_0001);
        close_out();
    end
endmodule : test_trmsc_top
`default_nettype wire
